// ---- rtl/spipm_top.v ----
// Serial pin-mode and bit-rate block: option and rate registers, pin steering,
// fault detection and the controller bit clock generator.
// Assumes a plain register port and pins synchronous to clock_i.
//
// Function
// - Unimplemented option bits 7,6,5,2 read zero
// - Target role ignores fault enable; select input
// - Controller without fault enable releases select
// - Controller with fault enable uses select pin
// - Select out enable chooses output over fault
// - Low select in controller sets fault flag
// - Output enable ignored unless single wire
// - Single wire: output enable drives data pin
// - Single wire target uses the MISO pin
// - Single wire controller uses the MOSI pin
// - Otherwise separate input and output pins
// - Halt in wait stops serial clocks
// - Rate register accessible at any time
// - Prescaler clocked from bus clock, feeds divider
// - Prescaler divides by code plus one
// - Divider feeds controller bit clock
// - Divider divides by two to code+1
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "spipm_defines.vh"
module spipm_top (
  // Clock and reset.
  input wire clock_i,
  input wire rst_i,
  // Register port.
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // System.
  input wire wait_mode_i,
  output reg irq_o,
  // Serial data out for the shifter and serial data in toward it.
  input wire tx_bit_i,
  output reg rx_bit_o,
  // Bit rate pulses toward the shifter, and the serial clock level.
  output reg bit_tick_o,
  output reg sclk_o,
  // MOSI pin; enable low means driving.
  input wire mosi_i,
  output reg mosi_o,
  output reg mosi_oe_n_o,
  output reg mosi_spi_owned_o,
  // MISO pin; enable low means driving.
  input wire miso_i,
  output reg miso_o,
  output reg miso_oe_n_o,
  output reg miso_spi_owned_o,
  // Select pin; enable low means driving.
  input wire ss_n_i,
  output reg ss_n_o,
  output reg ss_oe_n_o,
  output reg ss_spi_owned_o,
  // Transfer active from the shifter, used for automatic select.
  input wire busy_i
);
  reg [7:0] opt_q;
  reg [7:0] rate_q;
  reg [7:0] ctrl_q;
  reg [7:0] stat_q;
  reg [7:0] mask_q;
  reg [7:0] rdata_d;
  reg sclk_q;
  wire en_w;
  wire role_w;
  wire fde_w;
  wire sws_w;
  wire swoe_w;
  wire soe_w;
  wire run_w;
  wire pre_tick_w;
  wire bit_tick_w;
  wire edge_tick_w;
  wire fault_in_w;
  wire fault_set_w;
  wire [7:0] stat_d;

  assign en_w = ctrl_q[`SPIPM_CTRL_EN];
  assign role_w = ctrl_q[`SPIPM_CTRL_ROLE];
  assign soe_w = ctrl_q[`SPIPM_CTRL_SOE];
  assign fde_w = opt_q[`SPIPM_OPT_FDE] & role_w;
  assign sws_w = opt_q[`SPIPM_OPT_SWS];
  assign swoe_w = opt_q[`SPIPM_OPT_SWOE] & sws_w;

  // Clocks halt in wait only when asked; the generator restarts from zero on resume.
  assign run_w = en_w & role_w & ~(wait_mode_i & opt_q[`SPIPM_OPT_HIW]);

  // Register writes; the rate register is writable in any state.
  always @(posedge clock_i) begin
    if (rst_i) begin
      opt_q <= `SPIPM_OPT_RST;
      rate_q <= `SPIPM_RATE_RST;
      ctrl_q <= `SPIPM_CTRL_RST;
      mask_q <= `SPIPM_MASK_RST;
    end else if (wr_i) begin
      case (addr_i)
        `SPIPM_ADDR_OPT: opt_q <= wdata_i & `SPIPM_OPT_IMPL;
        `SPIPM_ADDR_RATE: rate_q <= wdata_i & `SPIPM_RATE_IMPL;
        `SPIPM_ADDR_CTRL: ctrl_q <= wdata_i & `SPIPM_CTRL_IMPL;
        `SPIPM_ADDR_MASK: mask_q <= wdata_i & `SPIPM_ST_IMPL;
        default: opt_q <= opt_q;
      endcase
    end
  end

  // Fault when acting as controller with fault input selected and select driven low.
  assign fault_in_w = en_w & fde_w & ~soe_w;
  assign fault_set_w = fault_in_w & ~ss_n_i;

  // Sticky status: set wins over a write-one clear in the same cycle.
  assign stat_d = fault_set_w ? (stat_q | 8'h01) :
                  ((wr_i && addr_i == `SPIPM_ADDR_STAT) ? (stat_q & ~wdata_i) : stat_q);

  always @(posedge clock_i) begin
    if (rst_i) begin
      stat_q <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      stat_q <= stat_d & `SPIPM_ST_IMPL;
      irq_o <= |(stat_d & mask_q & `SPIPM_ST_IMPL);
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    case (addr_i)
      `SPIPM_ADDR_OPT: rdata_d = opt_q;
      `SPIPM_ADDR_RATE: rdata_d = rate_q;
      `SPIPM_ADDR_CTRL: rdata_d = ctrl_q;
      `SPIPM_ADDR_STAT: rdata_d = stat_q;
      `SPIPM_ADDR_MASK: rdata_d = mask_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rdata_d : 8'h00;
    end
  end

  // Two-stage generator: prescaler then power-of-two divider, total 2 to 2048.
  spipm_prescaler u_pre (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(run_w),
    .prescale_code_i(rate_q[`SPIPM_RATE_PRE_HI:`SPIPM_RATE_PRE_LO]),
    .tick_o(pre_tick_w)
  );

  spipm_rate_divider u_div (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(run_w),
    .tick_i(pre_tick_w),
    .rate_divide_code_i(rate_q[`SPIPM_RATE_DIV_HI:`SPIPM_RATE_DIV_LO]),
    .bit_tick_o(bit_tick_w),
    .edge_tick_o(edge_tick_w)
  );

  // Serial clock toggles on each half period, so its rate is bus over the product.
  always @(posedge clock_i) begin
    if (rst_i || !run_w) begin
      sclk_q <= 1'b0;
      sclk_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else begin
      sclk_q <= edge_tick_w ? ~sclk_q : sclk_q;
      sclk_o <= edge_tick_w ? ~sclk_q : sclk_q;
      bit_tick_o <= bit_tick_w;
    end
  end

  // Pin steering; a pin the block does not own is left to general-purpose I/O.
  always @(posedge clock_i) begin
    if (rst_i) begin
      mosi_o <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      mosi_spi_owned_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
      miso_spi_owned_o <= 1'b0;
      ss_n_o <= 1'b1;
      ss_oe_n_o <= 1'b1;
      ss_spi_owned_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end else begin
      mosi_o <= tx_bit_i;
      miso_o <= tx_bit_i;
      if (!en_w) begin
        mosi_oe_n_o <= 1'b1;
        miso_oe_n_o <= 1'b1;
        mosi_spi_owned_o <= 1'b0;
        miso_spi_owned_o <= 1'b0;
        rx_bit_o <= 1'b0;
      end else if (sws_w && role_w) begin
        mosi_oe_n_o <= ~swoe_w;
        mosi_spi_owned_o <= 1'b1;
        miso_oe_n_o <= 1'b1;
        miso_spi_owned_o <= 1'b0;
        rx_bit_o <= mosi_i;
      end else if (sws_w) begin
        miso_oe_n_o <= ~swoe_w;
        miso_spi_owned_o <= 1'b1;
        mosi_oe_n_o <= 1'b1;
        mosi_spi_owned_o <= 1'b0;
        rx_bit_o <= miso_i;
      end else begin
        mosi_oe_n_o <= ~role_w;
        miso_oe_n_o <= role_w | ss_n_i;
        mosi_spi_owned_o <= 1'b1;
        miso_spi_owned_o <= 1'b1;
        rx_bit_o <= role_w ? miso_i : mosi_i;
      end
      // Select pin: target input, released, fault input, or automatic output.
      if (!en_w) begin
        ss_spi_owned_o <= 1'b0;
        ss_oe_n_o <= 1'b1;
        ss_n_o <= 1'b1;
      end else if (!role_w) begin
        ss_spi_owned_o <= 1'b1;
        ss_oe_n_o <= 1'b1;
        ss_n_o <= 1'b1;
      end else if (!fde_w) begin
        ss_spi_owned_o <= 1'b0;
        ss_oe_n_o <= 1'b1;
        ss_n_o <= 1'b1;
      end else begin
        ss_spi_owned_o <= 1'b1;
        ss_oe_n_o <= ~soe_w;
        ss_n_o <= ~busy_i;
      end
    end
  end
endmodule

// ---- rtl/spipm_defines.vh ----
// Constants for the serial pin-mode and bit-rate block: offsets, fields, resets, implemented-bit masks.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef SPIPM_DEFINES_VH
`define SPIPM_DEFINES_VH

// Register offsets on the plain register port.
`define SPIPM_ADDR_OPT 3'h0
`define SPIPM_ADDR_RATE 3'h1
`define SPIPM_ADDR_CTRL 3'h2
`define SPIPM_ADDR_STAT 3'h3
`define SPIPM_ADDR_MASK 3'h4

// Option control fields.
`define SPIPM_OPT_FDE 4
`define SPIPM_OPT_SWOE 3
`define SPIPM_OPT_HIW 1
`define SPIPM_OPT_SWS 0
`define SPIPM_OPT_IMPL 8'h1b

// Bit rate fields.
`define SPIPM_RATE_PRE_HI 6
`define SPIPM_RATE_PRE_LO 4
`define SPIPM_RATE_DIV_HI 2
`define SPIPM_RATE_DIV_LO 0
`define SPIPM_RATE_IMPL 8'h77

// Control register fields: enable, controller role, select out enable.
`define SPIPM_CTRL_EN 0
`define SPIPM_CTRL_ROLE 1
`define SPIPM_CTRL_SOE 2
`define SPIPM_CTRL_IMPL 8'h07

// Status and mask bits.
`define SPIPM_ST_FAULT 0
`define SPIPM_ST_IMPL 8'h01

// Reset values.
`define SPIPM_OPT_RST 8'h00
`define SPIPM_RATE_RST 8'h00
`define SPIPM_CTRL_RST 8'h00
`define SPIPM_MASK_RST 8'h00

`endif

// ---- rtl/spipm_prescaler.v ----
// Prescaler: divides the bus clock by code plus one, as a one-cycle enable pulse.
// Assumes one clock, synchronous active-high reset, and a halt input for wait.
`timescale 1ns/100ps
module spipm_prescaler (
  // Clock and reset.
  input wire clock_i,
  input wire rst_i,
  // Control.
  input wire run_i,
  input wire [2:0] prescale_code_i,
  // Output pulse.
  output reg tick_o
);
  reg [2:0] count_q;

  // Count up to the code; a code change takes effect at once, and the >= compare wraps a count past a lowered code, avoiding a stuck count.
  always @(posedge clock_i) begin
    if (rst_i || !run_i) begin
      count_q <= 3'h0;
      tick_o <= 1'b0;
    end else if (count_q >= prescale_code_i) begin
      count_q <= 3'h0;
      tick_o <= 1'b1;
    end else begin
      count_q <= count_q + 3'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ---- rtl/spipm_rate_divider.v ----
// Rate divider: divides prescaler pulses by 2 to the power of code plus one.
// Assumes the input pulse is one cycle wide and synchronous to the same clock.
`timescale 1ns/100ps
module spipm_rate_divider (
  // Clock and reset.
  input wire clock_i,
  input wire rst_i,
  // Control.
  input wire run_i,
  input wire tick_i,
  input wire [2:0] rate_divide_code_i,
  // Outputs.
  output reg bit_tick_o,
  output reg edge_tick_o
);
  reg [7:0] count_q;
  wire [7:0] last_w;

  // Divisor minus one, built as a run of code plus one low ones.
  // A left shift of two would overflow the byte at the top code.
  assign last_w = 8'hff >> (3'h7 - rate_divide_code_i);

  // One bit pulse per full divisor; an edge pulse at each half, which drives the serial clock.
  always @(posedge clock_i) begin
    if (rst_i || !run_i) begin
      count_q <= 8'h00;
      bit_tick_o <= 1'b0;
      edge_tick_o <= 1'b0;
    end else if (tick_i) begin
      edge_tick_o <= (count_q == last_w) || (count_q == (last_w >> 1));
      bit_tick_o <= (count_q >= last_w);
      count_q <= (count_q >= last_w) ? 8'h00 : count_q + 8'h01;
    end else begin
      bit_tick_o <= 1'b0;
      edge_tick_o <= 1'b0;
    end
  end
endmodule

// ---- tb/spipm_assertions.sv ----
// Checker for the pin-mode and bit-rate block, watching the top module's ports only.
// Assumes a bind from the testbench top file; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module spipm_assertions (
  // Clock and reset.
  input logic clock_i,
  input logic rst_i,
  // Register port and shifter side.
  input logic rd_i,
  input logic [7:0] rdata_o,
  input logic tx_bit_i,
  input logic busy_i,
  input logic bit_tick_o,
  // Pin side.
  input logic mosi_o,
  input logic miso_o,
  input logic mosi_oe_n_o,
  input logic mosi_spi_owned_o,
  input logic miso_oe_n_o,
  input logic miso_spi_owned_o,
  input logic ss_n_o,
  input logic ss_oe_n_o,
  input logic ss_spi_owned_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Read data must be zero outside the one answering cycle, so stale bytes never leak.
  a_read_data_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data outside read cycle");
  // The smallest division is two, so bit pulses can never come back to back.
  a_tick_is_pulse: assert property (bit_tick_o |=> !bit_tick_o) else $error("bit pulse too long");
  // Automatic select follows the transfer activity one cycle later.
  a_auto_select_level: assert property (!ss_oe_n_o && ss_spi_owned_o |-> ss_n_o == !$past(busy_i))
    else $error("select output wrong");
  // Pins handed back to general-purpose use are never driven by this block.
  a_select_released: assert property (!ss_spi_owned_o |-> ss_oe_n_o) else $error("select driven while free");
  a_mosi_released: assert property (!mosi_spi_owned_o |-> mosi_oe_n_o) else $error("mosi driven while free");
  a_miso_released: assert property (!miso_spi_owned_o |-> miso_oe_n_o) else $error("miso driven while free");
  // One role drives only one data pin at a time.
  a_single_data_driver: assert property (mosi_oe_n_o || miso_oe_n_o) else $error("both data pins driven");
  // A driven data pin carries the shifter bit of the previous cycle.
  a_mosi_data_path: assert property (!mosi_oe_n_o |-> mosi_o == $past(tx_bit_i)) else $error("mosi data wrong");
  a_miso_data_path: assert property (!miso_oe_n_o |-> miso_o == $past(tx_bit_i)) else $error("miso data wrong");
endmodule

// ---- tb/spipm_far_end.sv ----
// Far-end serial device: drives the data pins the block leaves free, and its select line.
// Assumes enables low while the block drives; the data lines have no pull devices.
`timescale 1ns/100ps
module spipm_far_end (
  // Clock.
  input logic clock_i,
  // Block side of the pins.
  input logic mosi_o,
  input logic mosi_oe_n_o,
  input logic miso_o,
  input logic miso_oe_n_o,
  input logic ss_n_o,
  input logic ss_oe_n_o,
  // Controls from the bench.
  input logic far_en_i,
  input logic far_bit_i,
  input logic sel_low_i,
  // Resolved line levels.
  output logic mosi_line_o,
  output logic miso_line_o,
  output logic ss_line_o
);
  logic mosi_last_q = 1'b0;
  logic miso_last_q = 1'b0;
  // A released line shows the inverse of its last level, so no stale bit passes as data.
  always @(posedge clock_i) begin
    mosi_last_q <= mosi_line_o;
    miso_last_q <= miso_line_o;
  end
  // The block wins where it drives; the far end fills in only when told to.
  assign mosi_line_o = !mosi_oe_n_o ? mosi_o : far_en_i ? far_bit_i : ~mosi_last_q;
  assign miso_line_o = !miso_oe_n_o ? miso_o : far_en_i ? far_bit_i : ~miso_last_q;
  // The far end drives its own select wherever the block does not, pulling it low to select or to collide.
  assign ss_line_o = !ss_oe_n_o ? ss_n_o : !sel_low_i;
endmodule

// ---- tb/spipm_top_tb_top.sv ----
// Testbench: registers, pin steering, bit rate, halt in wait and the fault interrupt.
// Assumes the far-end model and the checker are compiled before this file.
`timescale 1ns/100ps
`include "spipm_defines.vh"
module spipm_top_tb_top;
  logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, wait_mode_i = 1'b0, rd_seen = 1'b0;
  logic tx_bit_i = 1'b0, busy_i = 1'b0, far_en = 1'b0, far_bit = 1'b0, sel_low = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, v;
  logic [31:0] rng = 32'h0a239210, r;
  logic [7:0] exp_q[$];
  wire [7:0] rdata_o;
  wire irq_o, rx_bit_o, bit_tick_o, sclk_o, mosi_o, mosi_oe_n_o, mosi_own, miso_o, miso_oe_n_o, miso_own;
  wire ss_n_o, ss_oe_n_o, ss_own, mosi_line, miso_line, ss_line;
  int err_count = 0, check_count = 0, cyc = 0, n, c, m, h, t;
  // Rows: option, control, select low, receive check, expected enables and ownership.
  logic [31:0] rows [0:9] = '{32'h0003011e, 32'h0803011e, 32'h0903001c, 32'h0103013c, 32'h0901102b,
    32'h0101113b, 32'h0001112f, 32'h1003011f, 32'h10070117, 32'h1001112f};
  spipm_top DUT (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .wait_mode_i(wait_mode_i), .irq_o(irq_o), .tx_bit_i(tx_bit_i),
    .rx_bit_o(rx_bit_o), .bit_tick_o(bit_tick_o), .sclk_o(sclk_o), .mosi_i(mosi_line), .mosi_o(mosi_o),
    .mosi_oe_n_o(mosi_oe_n_o), .mosi_spi_owned_o(mosi_own), .miso_i(miso_line), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .miso_spi_owned_o(miso_own), .ss_n_i(ss_line), .ss_n_o(ss_n_o),
    .ss_oe_n_o(ss_oe_n_o), .ss_spi_owned_o(ss_own), .busy_i(busy_i));
  spipm_far_end u_far (.clock_i(clock_i), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .ss_n_o(ss_n_o), .ss_oe_n_o(ss_oe_n_o), .far_en_i(far_en),
    .far_bit_i(far_bit), .sel_low_i(sel_low), .mosi_line_o(mosi_line), .miso_line_o(miso_line),
    .ss_line_o(ss_line));
  // Clock of 8 ns.
  always #4 clock_i = ~clock_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Random shifter bit and activity each cycle, plus the hang guard.
  always @(posedge clock_i) begin
    rng <= xs(rng);
    tx_bit_i <= rng[0];
    busy_i <= rng[1];
    rd_seen <= rd_i;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  // Read answers are settled by the falling edge; the oldest note is the one owed.
  always @(negedge clock_i) if (rd_seen) check("read data", rdata_o, exp_q.pop_front());
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    wt(1);
    wr_i <= 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    wt(1);
    rd_i <= 1'b0;
    wt(1);
  endtask
  // Cycles between two bit pulses, with the serial clock changes and high cycles in that span.
  task automatic per(output int k, output int e, output int hi);
    logic s;
    @(negedge clock_i);
    while (bit_tick_o !== 1'b1) @(negedge clock_i);
    k = 0;
    e = 0;
    hi = 0;
    s = sclk_o;
    do begin
      @(negedge clock_i);
      k++;
      if (sclk_o !== s) e++;
      if (sclk_o === 1'b1) hi++;
      s = sclk_o;
    end while (bit_tick_o !== 1'b1 && k < 3000);
    wt(1);
  endtask
  // Bit pulses and serial clock changes over a fixed window; sampling starts on a falling edge to stay clear of updates.
  task automatic cnt(output int k, output int e);
    logic s;
    k = 0;
    e = 0;
    @(negedge clock_i);
    s = sclk_o;
    repeat (600) begin
      @(negedge clock_i);
      if (bit_tick_o === 1'b1) k++;
      if (sclk_o !== s) e++;
      s = sclk_o;
    end
    wt(1);
  endtask
  task automatic fault_pulse;
    sel_low <= 1'b1;
    wt(3);
    sel_low <= 1'b0;
    wt(2);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clock_i);
    check("interrupt", irq_o, e);
    wt(1);
  endtask
  task automatic stop_test;
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    wt(3);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(`SPIPM_ADDR_OPT, 8'hff);
    rd(`SPIPM_ADDR_OPT, 8'h1b);
    repeat (4) begin
      v = rng[7:0];
      wr(`SPIPM_ADDR_RATE, v);
      rd(`SPIPM_ADDR_RATE, v & 8'h77);
    end
    far_en <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      far_bit <= i[0];
      sel_low <= r[12];
      wr(`SPIPM_ADDR_OPT, r[31:24]);
      wr(`SPIPM_ADDR_CTRL, r[23:16]);
      wt(4);
      @(negedge clock_i);
      check("pins", {mosi_oe_n_o, miso_oe_n_o, ss_oe_n_o, mosi_own, miso_own, ss_own}, r[5:0]);
      if (r[8]) check("receive bit", rx_bit_o, i[0]);
      wt(1);
    end
    sel_low <= 1'b0;
    wr(`SPIPM_ADDR_CTRL, 8'h03);
    for (int i = 0; i < 8; i++) begin
      wr(`SPIPM_ADDR_RATE, {1'b0, i[2:0], 1'b0, ~i[2:0]});
      per(n, m, h);
      per(n, m, h);
      check("bit period", n[15:0], 16'((i + 1) << (8 - i)));
      check("serial clock edges", m[15:0], 16'd2);
      check("serial clock high", h[15:0], 16'((i + 1) << (7 - i)));
    end
    wr(`SPIPM_ADDR_RATE, 8'h00);
    wr(`SPIPM_ADDR_OPT, 8'h02);
    wait_mode_i <= 1'b1;
    wt(10);
    cnt(c, t);
    check("ticks in wait", c[15:0], 16'd0);
    check("serial clock edges", t[15:0], 16'd0);
    wr(`SPIPM_ADDR_OPT, 8'h00);
    wt(10);
    cnt(c, t);
    check("ticks in wait", c[15:0], 16'd300);
    check("serial clock edges", t[15:0], 16'd600);
    wait_mode_i <= 1'b0;
    wr(`SPIPM_ADDR_OPT, 8'h10);
    wr(`SPIPM_ADDR_STAT, 8'h01);
    wr(`SPIPM_ADDR_MASK, 8'h01);
    fault_pulse();
    rd(`SPIPM_ADDR_STAT, 8'h01);
    chk_irq(1'b1);
    wr(`SPIPM_ADDR_STAT, 8'h01);
    rd(`SPIPM_ADDR_STAT, 8'h00);
    chk_irq(1'b0);
    wr(`SPIPM_ADDR_MASK, 8'h00);
    fault_pulse();
    rd(`SPIPM_ADDR_STAT, 8'h01);
    chk_irq(1'b0);
    wr(`SPIPM_ADDR_STAT, 8'h01);
    wr(`SPIPM_ADDR_CTRL, 8'h01);
    fault_pulse();
    rd(`SPIPM_ADDR_STAT, 8'h00);
    wt(3);
    stop_test();
  end
endmodule
bind spipm_top spipm_assertions u_chk (.clock_i, .rst_i, .rd_i, .rdata_o, .tx_bit_i, .busy_i, .bit_tick_o,
  .mosi_o, .miso_o, .mosi_oe_n_o, .mosi_spi_owned_o, .miso_oe_n_o, .miso_spi_owned_o, .ss_n_o, .ss_oe_n_o,
  .ss_spi_owned_o);
